// ---- common/eeprom_cmd_pkg.sv ----
// shared constants and types for the serial eeprom command port
// assumes one 25 MHz system clock; the serial pins are asynchronous to it
package eeprom_cmd_pkg;
	// system clock and self-timed programming figures
	localparam int CLK_PERIOD_NS = 40;
	localparam int PROG_TIME_MS  = 10;
	localparam int PROG_TIME_NS  = PROG_TIME_MS * 1000000;
	// longest time, so the division rounds down
	localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;

	// array shape
	localparam int WORDS  = 64;
	localparam int UNIT_W = 16;
	localparam int ADDR_W = 7;
	localparam int IDX_W  = 6;

	// instruction lengths after the start bit, and data lengths
	localparam logic [4:0] CMD_LEN_X8   = 5'h09;
	localparam logic [4:0] CMD_LEN_X16  = 5'h08;
	localparam logic [4:0] DATA_LEN_X8  = 5'h08;
	localparam logic [4:0] DATA_LEN_X16 = 5'h10;
	localparam logic [6:0] ADDR_MAX_X8  = 7'h7F;
	localparam logic [6:0] ADDR_MAX_X16 = 7'h3F;
	localparam logic [15:0] ERASED_UNIT = 16'hFFFF;
	localparam logic        ORG_BYTE    = 1'h0;

	// opcodes and extended codes under opcode zero
	localparam logic [1:0] OPC_EXT   = 2'h0;
	localparam logic [1:0] OPC_WRITE = 2'h1;
	localparam logic [1:0] OPC_READ  = 2'h2;
	localparam logic [1:0] OPC_ERASE = 2'h3;
	localparam logic [1:0] EXT_PROG_DISABLE = 2'h0;
	localparam logic [1:0] EXT_FILL_ALL     = 2'h1;
	localparam logic [1:0] EXT_ERASE_ALL    = 2'h2;
	localparam logic [1:0] EXT_PROG_ENABLE  = 2'h3;

	// control states, gray along idle-shift-data-armed-prog
	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SHIFT  = 3'h1,
		ST_DATA   = 3'h3,
		ST_ARMED  = 3'h2,
		ST_PROG   = 3'h6,
		ST_READ   = 3'h5,
		ST_IGNORE = 3'h4
	} state_e;

	// pending programming operation
	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_ERASE = 2'h1,
		OP_ERASE_ALL = 2'h2,
		OP_FILL_ALL  = 2'h3
	} prog_op_e;
endpackage

// ---- rtl/serial_eeprom_command_port.sv ----
// serial command port of a 1 kbit eeprom with 64 x 16 storage
// assumes pins come straight from the host, asynchronous to clk
//
// Notes on behaviour
// - sequential read wraps top address to zero
// - programming is self-timed, clock irrelevant
// - write stores one whole byte or word
// - busy or ready shown while select high
// - org high gives words, low gives bytes
// - reset clears control, programming disabled
// - first one on data opens instruction
// - two opcode bits, zero extends via address
// - six or seven address bits, msb first
// - fully static serial clock, any slow rate
// - read sends dummy zero then data msb-first
// - read output changes only on serial clock rise
// - held select streams next unit, no dummy
// - enable gates erase and write commands
// - reads work whether enabled or not
// - opcodes read, write and erase decoded
// - extended codes enable, disable, erase-all, fill
// - erase sets ones, starts on select fall
// - busy drives zero, ready drives one
// - select low releases the output
// - write starts on select fall after data
// - ready one holds until start or deselect
// - fill-all programs without erasing first
module serial_eeprom_command_port #(
	parameter int PROG_CYCLES = eeprom_cmd_pkg::PROG_CYCLES_DEF // programming length
) (
	input  wire logic clk,        // 25 MHz system clock
	input  wire logic reset,      // synchronous power-on reset, high
	input  wire logic selIn,      // select pin from host
	input  wire logic sclkIn,     // serial clock pin from host
	input  wire logic dataIn,     // serial data pin from host
	input  wire logic orgIn,      // organisation strap, high for words
	output logic      dataOut,    // serial data output value
	output logic      dataOutEnN  // low while the output is driven
);
	import eeprom_cmd_pkg::*;

	localparam int PROG_W = $clog2(PROG_CYCLES + 1);
	localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROG_CYCLES - 1);

	// pin synchroniser stages: {org, data, sclk, select}
	logic [3:0]        pinS0_q;      // first stage, read by stage two only
	logic [3:0]        pinS1_q;      // second stage
	logic [3:0]        pinS2_q;      // third stage
	logic [3:0]        pinF_q;       // filtered level
	logic              sclkPrev_q;   // filtered clock one cycle back
	state_e            state_q;      // control state
	prog_op_e          op_q;         // pending programming operation
	logic              enable_q;     // programming permitted
	logic              showStat_q;   // ready/busy shown on output
	logic              orgLat_q;     // organisation caught at start bit
	logic [4:0]        bitCnt_q;     // bits taken or still to send
	logic [8:0]        cmdSr_q;      // opcode and address shifter
	logic [15:0]       dataSr_q;     // write data shifter
	logic [6:0]        addrLat_q;    // address for programming
	logic [6:0]        addrPtr_q;    // read pointer
	logic [15:0]       outSr_q;      // read data shifter
	logic              readOut_q;    // read bit for the output
	logic [PROG_W-1:0] progCnt_q;    // programming timer
	logic              dataOut_q;    // registered output value
	logic              driveN_q;     // registered output enable
	logic [15:0]       mem [WORDS];  // storage, never reset

	// filtered pins and edge
	wire selF  = pinF_q[0];
	wire sclkF = pinF_q[1];
	wire dinF  = pinF_q[2];
	wire orgF  = pinF_q[3];
	wire rise  = sclkF & ~sclkPrev_q;

	// decode of the instruction on its last bit
	wire        byteMode = (orgLat_q == ORG_BYTE);
	wire [8:0]  cmdNext  = {cmdSr_q[7:0], dinF};
	wire [15:0] dataNext = {dataSr_q[14:0], dinF};
	wire [1:0]  opcode   = byteMode ? cmdNext[8:7] : cmdNext[7:6];
	wire [1:0]  extCode  = byteMode ? cmdNext[6:5] : cmdNext[5:4];
	wire [6:0]  addrIn   = byteMode ? cmdNext[6:0] : {1'h0, cmdNext[5:0]};
	wire [4:0]  cmdLen   = byteMode ? CMD_LEN_X8 : CMD_LEN_X16;
	wire [4:0]  unitLen  = byteMode ? DATA_LEN_X8 : DATA_LEN_X16;
	wire [6:0]  addrMax  = byteMode ? ADDR_MAX_X8 : ADDR_MAX_X16;
	wire        lastCmd  = (bitCnt_q == cmdLen - 5'h01);
	wire        lastData = (bitCnt_q == unitLen - 5'h01);
	wire [6:0]  addrNext = (addrPtr_q == addrMax) ? 7'h00 : addrPtr_q + 7'h01;
	wire        progDone = (state_q == ST_PROG) && (progCnt_q == PROG_LAST);
	wire [15:0] unitData = byteMode ? {dataSr_q[7:0], dataSr_q[7:0]} : dataSr_q;

	// word index of a byte or word address
	function automatic [5:0] wordIdx(input logic [6:0] a, input logic bm);
		wordIdx = bm ? a[6:1] : a[5:0];
	endfunction

	// read one unit, left aligned so bit 15 leaves first
	function automatic [15:0] readUnit(input logic [6:0] a, input logic bm,
		input logic [15:0] w);
		if (!bm)
			readUnit = w;
		else
			readUnit = a[0] ? {w[15:8], 8'h00} : {w[7:0], 8'h00};
	endfunction

	// replace one byte lane, or the whole word in word mode
	function automatic [15:0] laneMerge(input logic [15:0] old,
		input logic [15:0] val, input logic bm, input logic lane);
		if (!bm)
			laneMerge = val;
		else
			laneMerge = lane ? {val[7:0], old[7:0]} : {old[15:8], val[7:0]};
	endfunction

	wire [15:0] rdFirst = readUnit(addrIn, byteMode, mem[wordIdx(addrIn, byteMode)]);
	wire [15:0] rdNext  = readUnit(addrNext, byteMode, mem[wordIdx(addrNext, byteMode)]);
	wire [5:0]  progIdx = wordIdx(addrLat_q, byteMode);

	// three-stage pin capture; a level counts once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pinS0_q    <= 4'h0;
			pinS1_q    <= 4'h0;
			pinS2_q    <= 4'h0;
			pinF_q     <= 4'h0;
			sclkPrev_q <= 1'h0;
		end
		else
		begin
			pinS0_q    <= {orgIn, dataIn, sclkIn, selIn};
			pinS1_q    <= pinS0_q;
			pinS2_q    <= pinS1_q;
			pinF_q     <= (pinS1_q & pinS2_q) | (pinF_q & (pinS1_q ^ pinS2_q));
			sclkPrev_q <= sclkF;
		end
	end

	// instruction sequencer; edge driven, so any slow serial rate works
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_q    <= ST_IDLE;  // ready for a new instruction
			enable_q   <= 1'h0;     // write-inhibited after power-up
			op_q       <= OP_WRITE;
			showStat_q <= 1'h0;
			orgLat_q   <= 1'h1;
			bitCnt_q   <= 5'h00;
			cmdSr_q    <= 9'h000;
			dataSr_q   <= 16'h0000;
			addrLat_q  <= 7'h00;
			addrPtr_q  <= 7'h00;
			outSr_q    <= 16'h0000;
			readOut_q  <= 1'h0;
			progCnt_q  <= '0;
		end
		else
		begin
			unique case (state_q)
				ST_IDLE:
				begin
					// first one sampled with select high opens a command
					if (selF && rise && dinF)
					begin
						state_q    <= ST_SHIFT;
						orgLat_q   <= orgF; // strap read per command
						showStat_q <= 1'h0; // ready indication ends
						bitCnt_q   <= 5'h00;
						cmdSr_q    <= 9'h000;
					end
				end
				ST_SHIFT:
				begin
					if (!selF)
						state_q <= ST_IDLE; // partial command dropped
					else if (rise)
					begin
						cmdSr_q  <= cmdNext; // msb first
						bitCnt_q <= bitCnt_q + 5'h01;
						if (lastCmd)
						begin
							addrLat_q <= addrIn;
							bitCnt_q  <= 5'h00;
							unique case (opcode)
								OPC_READ:
								begin
									// no enable check on reads
									state_q   <= ST_READ;
									addrPtr_q <= addrIn;
									outSr_q   <= rdFirst;
									readOut_q <= 1'h0; // dummy zero
									bitCnt_q  <= unitLen;
								end
								OPC_WRITE:
								begin
									op_q    <= OP_WRITE;
									state_q <= ST_DATA;
								end
								OPC_ERASE:
								begin
									op_q    <= OP_ERASE;
									state_q <= enable_q ? ST_ARMED : ST_IGNORE;
								end
								OPC_EXT:
								begin
									// low address bits are don't care
									unique case (extCode)
										EXT_PROG_ENABLE:
										begin
											enable_q <= 1'h1;
											state_q  <= ST_IGNORE;
										end
										EXT_PROG_DISABLE:
										begin
											enable_q <= 1'h0;
											state_q  <= ST_IGNORE;
										end
										EXT_ERASE_ALL:
										begin
											op_q    <= OP_ERASE_ALL;
											state_q <= enable_q ? ST_ARMED : ST_IGNORE;
										end
										EXT_FILL_ALL:
										begin
											op_q    <= OP_FILL_ALL;
											state_q <= ST_DATA;
										end
									endcase
								end
							endcase
						end
					end
				end
				ST_DATA:
				begin
					if (!selF)
						state_q <= ST_IDLE; // short data: nothing runs
					else if (rise)
					begin
						dataSr_q <= dataNext;
						bitCnt_q <= bitCnt_q + 5'h01;
						if (lastData)
							state_q <= enable_q ? ST_ARMED : ST_IGNORE;
					end
				end
				ST_ARMED:
				begin
					// select fall starts the timed cycle
					if (!selF)
					begin
						state_q    <= ST_PROG;
						progCnt_q  <= '0;
						showStat_q <= 1'h1;
					end
					else if (rise)
						state_q <= ST_IGNORE; // extra clock cancels the command
				end
				ST_PROG:
				begin
					// counts on clk only; serial pins are ignored
					if (progDone)
						state_q <= ST_IDLE;
					else
						progCnt_q <= progCnt_q + 1'b1;
				end
				ST_READ:
				begin
					if (!selF)
						state_q <= ST_IDLE;
					else if (rise) // shifts only on serial rises
					begin
						if (bitCnt_q == 5'h00)
						begin
							// next unit straight away, pointer wraps
							addrPtr_q <= addrNext;
							readOut_q <= rdNext[15];
							outSr_q   <= {rdNext[14:0], 1'h0};
							bitCnt_q  <= unitLen - 5'h01;
						end
						else
						begin
							readOut_q <= outSr_q[15];
							outSr_q   <= {outSr_q[14:0], 1'h0};
							bitCnt_q  <= bitCnt_q - 5'h01;
						end
					end
				end
				ST_IGNORE:
				begin
					// wait out the rest of a finished or refused command
					if (!selF)
						state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// storage update when the timed cycle ends
	always_ff @(posedge clk)
	begin
		if (progDone)
		begin
			unique case (op_q)
				OP_WRITE: // implicit erase, whole unit at once
					mem[progIdx] <= laneMerge(mem[progIdx], dataSr_q, byteMode,
						addrLat_q[0]);
				OP_ERASE: // all ones
					mem[progIdx] <= laneMerge(mem[progIdx], ERASED_UNIT, byteMode,
						addrLat_q[0]);
				OP_ERASE_ALL:
					for (int i = 0; i < WORDS; i++)
						mem[i] <= ERASED_UNIT;
				OP_FILL_ALL: // only clears bits, so erase-all must come first
					for (int i = 0; i < WORDS; i++)
						mem[i] <= mem[i] & unitData;
			endcase
		end
	end

	// output pin: busy zero, ready one, or read data; released when deselected
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dataOut_q <= 1'h0;
			driveN_q  <= 1'h1;
		end
		else
		begin
			driveN_q <= ~(selF && (state_q == ST_PROG || state_q == ST_READ
				|| showStat_q));
			if (state_q == ST_PROG)
				dataOut_q <= 1'h0; // busy
			else if (state_q == ST_READ)
				dataOut_q <= readOut_q;
			else
				dataOut_q <= 1'h1; // ready
		end
	end

	assign dataOut    = dataOut_q;
	assign dataOutEnN = driveN_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence readLoad_s;
		state_q == ST_SHIFT && selF && rise && lastCmd && opcode == OPC_READ;
	endsequence

	sequence unitWrap_s;
		state_q == ST_READ && selF && rise && bitCnt_q == 5'h00
			&& addrPtr_q == addrMax;
	endsequence

	read_wrap_a: assert property (unitWrap_s |=> addrPtr_q == 7'h00)
		else $error("read pointer did not wrap to zero");
	prog_timed_a: assert property (state_q == ST_PROG && !progDone
		|=> state_q == ST_PROG)
		else $error("programming cycle ended early");
	busy_shown_a: assert property (state_q == ST_PROG && selF
		|=> !dataOutEnN && !dataOut)
		else $error("busy not driven as zero");
	ready_shown_a: assert property (showStat_q && selF && state_q != ST_PROG
		&& state_q != ST_READ |=> !dataOutEnN && dataOut)
		else $error("ready not driven as one");
	desel_release_a: assert property (!selF |=> dataOutEnN)
		else $error("output not released on deselect");
	dummy_zero_a: assert property (readLoad_s
		|=> state_q == ST_READ && !readOut_q && bitCnt_q == unitLen)
		else $error("dummy zero missing before read data");
	read_hold_a: assert property (state_q == ST_READ && !rise
		|=> $stable(readOut_q))
		else $error("read output moved without a clock rise");
	prog_guard_a: assert property (state_q == ST_PROG |-> enable_q)
		else $error("programming ran while disabled");
	// the default disable would hide every attempt, since reset is the antecedent here
	reset_state_a: assert property (disable iff (1'b0) reset |=> !enable_q && state_q == ST_IDLE)
		else $error("reset left control state set");
	partial_drop_a: assert property ((state_q == ST_SHIFT || state_q == ST_DATA)
		&& !selF |=> state_q == ST_IDLE)
		else $error("partial instruction not dropped");
	sel_start_a: assert property (state_q == ST_ARMED && !selF
		|=> state_q == ST_PROG && progCnt_q == '0)
		else $error("select fall did not start programming");
endmodule

// ---- sim/host_serial_model.sv ----
// host side of the serial command pins: select, serial clock and data
// assumes clk is the 40 ns system clock; pins change only at its falling edge
module host_serial_model (
	input  wire logic clk,     // system clock, pacing only
	input  wire logic dout,    // device serial output value
	input  wire logic doutEnN, // device output enable, low while driving
	output logic      sel,     // select to the device
	output logic      sclk,    // serial clock to the device
	output logic      din      // serial data to the device
);
	timeunit 1ns;
	timeprecision 1ps;
	// nothing holds the line when released, so show the opposite level to expose late drive
	wire qLine = doutEnN ? ~dout : dout;
	// 520 ns phases keep the period above 1 us and well past the pin filter
	localparam int HALF = 13;
	// idle pins, serial clock resting low outside frames
	initial
	begin
		sel = 1'b0;
		sclk = 1'b0;
		din = 1'b0;
	end
	// wait n falling edges of the system clock
	task automatic waitn(input int n);
		repeat (n) @(negedge clk);
	endtask
	// raise select while the serial clock rests low
	task automatic open_frame();
		sel = 1'b1;
		waitn(HALF);
	endtask
	// one bit: data set up, clock high, output sampled just before the fall
	task automatic bit_io(input logic d, output logic q);
		din = d;
		waitn(HALF);
		sclk = 1'b1;
		waitn(HALF);
		q = qLine;
		sclk = 1'b0;
	endtask
	// select drops before any further rise, then the deselect gap
	task automatic close_frame();
		sel = 1'b0;
		din = ~din; // no stale data level once the frame is over
		waitn(8);
	endtask
endmodule

// ---- sim/tb_top.sv ----
// self-checking bench for the serial eeprom command port
// assumes the host model drives the pins; a reference array mirrors the memory
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import eeprom_cmd_pkg::*;
	localparam int PROG = 200; // short programming time keeps the run brief
	logic        clk;        // system clock
	logic        reset;      // synchronous reset
	logic        orgIn;      // organisation strap
	logic        selIn;      // select pin
	logic        sclkIn;     // serial clock pin
	logic        dataIn;     // serial data pin
	logic        dataOut;    // device output value
	logic        dataOutEnN; // device output enable, low driving
	int unsigned errors;     // mismatches seen
	int unsigned cmp_count;  // comparisons made
	logic [15:0] mem [WORDS]; // reference contents, word indexed
	bit          wrEn;       // reference programming enable

	serial_eeprom_command_port #(.PROG_CYCLES(PROG)) serial_eeprom_command_port_i (
		.clk(clk), .reset(reset), .selIn(selIn), .sclkIn(sclkIn), .dataIn(dataIn),
		.orgIn(orgIn), .dataOut(dataOut), .dataOutEnN(dataOutEnN));
	host_serial_model host_serial_model_i (
		.clk(clk), .dout(dataOut), .doutEnN(dataOutEnN), .sel(selIn), .sclk(sclkIn),
		.din(dataIn));

	// free-running 25 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// compare and count; unknown bits match only unknown bits in the same place
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// the one place the run ends
	task automatic results();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic int alen();
		return orgIn ? 6 : 7;
	endfunction
	function automatic int dlen();
		return orgIn ? 16 : 8;
	endfunction
	// expected unit at an address; byte lanes follow address bit 0
	function automatic logic [15:0] unit_at(input int a);
		if (orgIn)
			return mem[a];
		return a[0] ? {8'h00, mem[a / 2][15:8]} : {8'h00, mem[a / 2][7:0]};
	endfunction
	// whole-unit store into the reference
	task automatic put(input int a, input logic [15:0] d);
		if (orgIn)
			mem[a] = d;
		else if (a[0])
			mem[a / 2][15:8] = d[7:0];
		else
			mem[a / 2][7:0] = d[7:0];
	endtask
	// shift n bits msb first, keeping the last sampled output bit
	task automatic send(input logic [31:0] v, input int n, output logic q);
		for (int i = n - 1; i >= 0; i--)
			host_serial_model_i.bit_io(v[i], q);
	endtask
	// busy while the timer runs, ready afterwards, released on deselect
	task automatic status();
		int n;
		host_serial_model_i.open_frame();
		check({dataOutEnN, dataOut}, 2'h0); // busy driven low
		n = 0;
		while (dataOut !== 1'b1 && n < 2 * PROG)
		begin
			@(negedge clk);
			n++;
		end
		check(n >= PROG - 20 && n < PROG, 1'b1); // timed inside, serial clock stopped
		host_serial_model_i.waitn(20);
		check({dataOutEnN, dataOut}, 2'h1); // ready holds while selected
		host_serial_model_i.close_frame();
		check(dataOutEnN, 1'b1); // output released
	endtask
	// one complete instruction with the reference updated alongside
	task automatic instr(input logic [1:0] op, input int a, input logic [15:0] d);
		logic       q;
		logic [1:0] ext;
		bit         prog;
		ext = 2'(a >> (alen() - 2));
		prog = wrEn && (op != OPC_EXT || ext == EXT_ERASE_ALL || ext == EXT_FILL_ALL);
		host_serial_model_i.open_frame();
		send({1'b1, op}, 3, q); // start bit, then opcode
		send(a, alen(), q);
		if (op == OPC_WRITE || (op == OPC_EXT && ext == EXT_FILL_ALL))
			send(d, dlen(), q);
		host_serial_model_i.close_frame();
		if (op == OPC_EXT && ext == EXT_PROG_ENABLE)
			wrEn = 1'b1;
		if (op == OPC_EXT && ext == EXT_PROG_DISABLE)
			wrEn = 1'b0;
		if (prog)
		begin
			for (int i = 0; i < WORDS; i++)
				if (op == OPC_EXT)
					mem[i] = (ext == EXT_ERASE_ALL) ? ERASED_UNIT :
						mem[i] & (orgIn ? d : {2{d[7:0]}});
			if (op != OPC_EXT)
				put(a, op == OPC_ERASE ? ERASED_UNIT : d);
			status();
		end
	endtask
	// extended command; code in the top two address bits, lowest two are random filler, the rest zero
	task automatic cmd_ext(input logic [1:0] e, input logic [15:0] d);
		instr(OPC_EXT, (int'(e) << (alen() - 2)) | int'($urandom % 4), d);
	endtask
	// read count units from a; dummy zero once, none between units
	task automatic rd(input int a, input int count);
		logic        q;
		logic [15:0] v;
		host_serial_model_i.open_frame();
		send({1'b1, OPC_READ}, 3, q);
		send(a, alen(), q);
		check(q, 1'b0); // leading dummy bit
		repeat (count)
		begin
			for (int i = 0; i < dlen(); i++)
			begin
				host_serial_model_i.bit_io(1'($urandom), q);
				v = {v[14:0], q};
			end
			check(v & (orgIn ? 16'hFFFF : 16'h00FF), unit_at(a));
			a = (a + 1) % (orgIn ? WORDS : 2 * WORDS);
		end
		host_serial_model_i.close_frame();
	endtask
	// watchdog sized at about twice the expected run length
	initial
	begin
		repeat (80000) @(posedge clk);
		errors++;
		results();
	end
	// main sequence: word organisation first, then bytes
	initial
	begin
		logic q;
		int   a;
		errors = 0;
		cmp_count = 0;
		wrEn = 1'b0;
		reset = 1'b1;
		orgIn = 1'b1;
		void'($urandom(32'hCAD88A1D));
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		host_serial_model_i.waitn(6);
		check(dataOutEnN, 1'b1); // quiet after reset
		for (int o = 1; o >= 0; o--)
		begin
			orgIn = 1'(o); // strap picks the unit size
			cmd_ext(EXT_PROG_ENABLE, 16'h0000);
			cmd_ext(EXT_ERASE_ALL, 16'h0000);
			rd(orgIn ? 62 : 126, 3); // runs over the top address
			cmd_ext(EXT_FILL_ALL, 16'($urandom)); // fills over the erased array; no erase of its own
			instr(OPC_WRITE, 0, 16'($urandom)); // distinct unit at zero
			rd(orgIn ? 63 : 127, 2); // top unit, then wrapped zero
			rd(int'($urandom % 20), 2);
			repeat (3)
			begin
				a = int'($urandom % (orgIn ? 64 : 128));
				instr(OPC_WRITE, a, 16'($urandom)); // one whole unit
				rd(a, 2);
				instr(OPC_ERASE, a, 16'h0000);
				rd(a, 1);
			end
			// deselect mid-address must leave everything untouched
			host_serial_model_i.open_frame();
			send({1'b1, OPC_WRITE}, 3, q);
			send(32'h5, 3, q);
			host_serial_model_i.close_frame();
			rd(a, 1);
			cmd_ext(EXT_PROG_DISABLE, 16'h0000); // guard after writing
			instr(OPC_WRITE, a, 16'h1234); // refused while disabled
			cmd_ext(EXT_ERASE_ALL, 16'h0000);
			rd(a, 4); // reads unaffected
		end
		results();
	end
endmodule
